// >>> src/two_wire_bus_control.v
// two_wire_bus_control.v: control of a byte-wide two-wire bus port
// assumes: cpu port and timer pulse on clk; pins open-drain outside
// How it works
// R1: cpu reads and writes control byte
// R2: hardware sets event flag, clears stop
// R3: clock select only used as master
// R4: timer clock: overflow rate over two
// R5: software runs timer in auto-reload mode
// R6: else clock from high/low counts
// R7: start waits free bus, half period
// R8: start while master gives repeated start
// R9: start accepted anytime; none when clear
// R10: master stop, flag clears at stop
// R11: slave stop: internal recovery only
// R12: both flags: stop then start
// R13: ack asserted pulls SDA low
// R14: ack clear leaves SDA high
// R15: event flag set on states, cpu clears
// R16: irq when flag and both enables
// R17: enable bit turns function on
// R18: high/low counts set SCL phases
// R19: code f8 never sets event flag
// R20: general call only when enabled
// R21: disabled: lines free, no events
`timescale 1ns/1ps
`default_nettype none
`include "bus_control_regs.vh"
module two_wire_bus_control (
    input  wire       clk,
    input  wire       rst_b,
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_en,
    input  wire       rd_en,
    output reg  [7:0] rdata,
    input  wire       timer_ovf,
    input  wire       global_irq_enable,
    input  wire       bus_irq_enable,
    output reg        irq,
    input  wire       scl_in,
    output reg        scl_out,
    output reg        scl_oe,
    input  wire       sda_in,
    output reg        sda_out,
    output reg        sda_oe
);
    // ---------------------------------------------------------------
    // master states
    // ---------------------------------------------------------------
    localparam [3:0] M_IDLE  = 4'h0;
    localparam [3:0] M_WAIT  = 4'h1;
    localparam [3:0] M_DLY   = 4'h2;
    localparam [3:0] M_SDA   = 4'h3;
    localparam [3:0] M_XFER  = 4'h4;
    localparam [3:0] M_STOP1 = 4'h5;
    localparam [3:0] M_STOP2 = 4'h6;
    localparam [3:0] M_STOP3 = 4'h7;
    localparam [3:0] M_RS1   = 4'h8;
    localparam [3:0] M_RS2   = 4'h9;

    // control byte fields
    reg        en, start_request_flag, stop_request_flag, si, aa, scl_source_select;
    reg  [7:0] status, own_addr, scl_high_count, scl_low_count;
    // byte engine
    reg  [7:0] shift;
    reg  [3:0] bitcnt;
    reg        armed, bit_in, tx, ack_low, addr_phase;
    reg        matched, gc_flag, addressed, master, busy;
    // master sequencer
    reg  [3:0] mstate, mstate_d;
    reg        sda_m_low, scl_m_low, rs_flag, si_prev;
    reg        scl_d, sda_d;
    wire       scl_s, sda_s, tick;

    // ---------------------------------------------------------------
    // pin synchronisers and line events
    // ---------------------------------------------------------------
    bit_sync u_scl_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (scl_in),
        .q     (scl_s)
    );
    bit_sync u_sda_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .d     (sda_in),
        .q     (sda_s)
    );
    wire start_det = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_det  = scl_s & scl_d & ~sda_d & sda_s;
    wire scl_rise  = scl_s & ~scl_d;
    wire scl_fall  = ~scl_s & scl_d;

    // ---------------------------------------------------------------
    // master clock source
    // ---------------------------------------------------------------
    // restart on any phase change so each phase is a full count
    wire restart = (scl_s ^ scl_d) | (mstate != mstate_d) | (si ^ si_prev);
    scl_rate_gen u_rate (
        .clk       (clk),
        .rst_b     (rst_b),
        .use_timer (scl_source_select),          // [R3] [R4] [R6]
        .timer_ovf (timer_ovf),
        .restart   (restart),
        .scl_high  (scl_s),
        .high_cnt  (scl_high_count), // [R18]
        .low_cnt   (scl_low_count),
        .tick      (tick)
    );

    // ---------------------------------------------------------------
    // engine decode
    // ---------------------------------------------------------------
    wire [7:0] nxt_byte = {shift[6:0], bit_in};
    wire       hit_own  = nxt_byte[7:1] == own_addr[7:1];
    wire       hit_gc   = (nxt_byte[7:1] == 7'h00) & own_addr[0]; // [R20]
    wire       in_xfer  = master & (mstate == M_XFER);
    wire       eng_ok   = in_xfer | (~master & addressed);
    wire       eng_low  = eng_ok & armed & ~si &
                          ((~bitcnt[3] & tx & ~shift[7]) |
                           (bitcnt[3] & ack_low));
    wire       si_fell  = si_prev & ~si;
    wire       wr_ctrl  = wr_en & (addr == `CTRL_ADDR);
    wire       lost     = in_xfer & ~bitcnt[3] & tx & shift[7] & ~sda_s;

    // ---------------------------------------------------------------
    // registers, byte engine and master sequencer
    // ---------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            en <= 1'b0; start_request_flag <= 1'b0; stop_request_flag <= 1'b0;
            si <= 1'b0; aa <= 1'b0; scl_source_select <= 1'b0;
            status <= `STAT_RST;
            own_addr <= `BYTE_RST;
            scl_high_count <= `SCL_RST;
            scl_low_count <= `SCL_RST;
            shift <= `BYTE_RST;
            bitcnt <= 4'h0;
            armed <= 1'b0; bit_in <= 1'b1; tx <= 1'b0;
            ack_low <= 1'b0; addr_phase <= 1'b0;
            matched <= 1'b0; gc_flag <= 1'b0;
            addressed <= 1'b0; master <= 1'b0; busy <= 1'b0;
            mstate <= M_IDLE; mstate_d <= M_IDLE;
            sda_m_low <= 1'b0; scl_m_low <= 1'b0;
            rs_flag <= 1'b0; si_prev <= 1'b0;
            scl_d <= 1'b1; sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
            si_prev <= si;
            mstate_d <= mstate;
            // cpu writes; a clear of the event flag goes first so
            // an event in the same cycle still sets it
            if (wr_ctrl) begin
                en    <= wdata[`EN_BIT];     // [R17]
                start_request_flag   <= wdata[`STA_BIT];
                stop_request_flag   <= wdata[`STO_BIT];
                aa    <= wdata[`AA_BIT];
                scl_source_select <= wdata[`SCL_SOURCE_SELECT_BIT];
                if (!wdata[`SI_BIT] && si) begin
                    si     <= 1'b0;          // [R15] only a 0 clears
                    status <= `ST_NONE;      // [R19]
                end
            end
            if (wr_en && addr == `DATA_ADDR) shift <= wdata;
            if (wr_en && addr == `OWN_ADDR) own_addr <= wdata;
            if (wr_en && addr == `SCLH_ADDR) scl_high_count <= wdata;
            if (wr_en && addr == `SCLL_ADDR) scl_low_count <= wdata;
            if (!en) begin
                // idle everything and let go of both lines
                master <= 1'b0; addressed <= 1'b0;   // [R21]
                armed <= 1'b0; bitcnt <= 4'h0; busy <= 1'b0;
                ack_low <= 1'b0; addr_phase <= 1'b0;
                sda_m_low <= 1'b0; scl_m_low <= 1'b0;
                mstate <= M_IDLE;
            end else begin
                // start or repeated start seen on the bus
                if (start_det) begin
                    busy <= 1'b1;
                    bitcnt <= 4'h0;
                    armed <= 1'b0;
                    addr_phase <= 1'b1;
                    ack_low <= 1'b0;
                    tx <= master;
                    if (!master && addressed) begin
                        addressed <= 1'b0;
                        si <= 1'b1;
                        status <= `ST_SSTOP;
                    end
                end
                // stop frees the bus and ends a slave transfer
                if (stop_det) begin
                    busy <= 1'b0;
                    armed <= 1'b0;
                    addr_phase <= 1'b0;
                    if (addressed) begin
                        addressed <= 1'b0;
                        si <= 1'b1;
                        status <= `ST_SSTOP;
                    end
                end
                // sample on rising clock; lost arbitration drops out
                if (scl_rise && armed) begin
                    bit_in <= sda_s;
                    if (lost) begin
                        master <= 1'b0;
                        mstate <= M_IDLE;
                        scl_m_low <= 1'b0;
                        tx <= 1'b0;
                        addr_phase <= 1'b0;
                        si <= 1'b1;
                        status <= `ST_ARB;
                    end
                end
                // shift on falling clock, finish after the ack bit
                if (scl_fall) begin
                    if (!armed) begin
                        armed <= 1'b1;
                    end else if (!bitcnt[3]) begin
                        shift <= nxt_byte;
                        bitcnt <= bitcnt + 4'h1;
                        if (bitcnt == 4'h7) begin
                            matched <= hit_own | hit_gc;
                            gc_flag <= hit_gc & ~hit_own;
                            // low only when asked, else SDA stays high
                            ack_low <= ~tx & aa &           // [R13] [R14]
                                (addr_phase ? (~master & (hit_own | hit_gc))
                                            : (master | addressed));
                        end
                    end else begin
                        bitcnt <= 4'h0;
                        ack_low <= 1'b0;
                        addr_phase <= 1'b0;
                        if (in_xfer) begin
                            si <= 1'b1;                     // [R15]
                            if (addr_phase) begin
                                tx <= ~shift[0];
                                if (shift[0])
                                    status <= bit_in ? `ST_MR_NACK : `ST_MR_ACK;
                                else
                                    status <= bit_in ? `ST_MW_NACK : `ST_MW_ACK;
                            end else if (tx) begin
                                status <= bit_in ? `ST_MT_NACK : `ST_MT_ACK;
                            end else begin
                                status <= ack_low ? `ST_MD_ACK : `ST_MD_NACK;
                            end
                        end else if (!master && addr_phase && matched && ack_low) begin
                            addressed <= 1'b1;
                            si <= 1'b1;
                            tx <= shift[0];
                            if (shift[0]) status <= `ST_SR;
                            else status <= gc_flag ? `ST_SG : `ST_SW;
                        end else if (!master && addressed) begin
                            si <= 1'b1;
                            if (tx) begin
                                status <= bit_in ? `ST_ST_NACK : `ST_ST_ACK;
                                if (bit_in) addressed <= 1'b0;
                            end else begin
                                if (gc_flag)
                                    status <= ack_low ? `ST_SGD_ACK : `ST_SGD_NACK;
                                else
                                    status <= ack_low ? `ST_SD_ACK : `ST_SD_NACK;
                                if (!ack_low) addressed <= 1'b0;
                            end
                        end
                    end
                end
                // slave-side stop: recover without touching the bus
                if (stop_request_flag && !master) begin
                    stop_request_flag <= 1'b0;                            // [R11] [R12]
                    addressed <= 1'b0;
                end
                case (mstate)
                    M_IDLE: begin
                        // start request may come in any mode
                        if (start_request_flag && !master) begin           // [R9]
                            rs_flag <= 1'b0;
                            if (busy) begin
                                mstate <= M_WAIT;
                            end else begin
                                master <= 1'b1;             // [R7]
                                sda_m_low <= 1'b1;
                                mstate <= M_SDA;
                            end
                        end
                    end
                    M_WAIT: begin
                        if (!busy) mstate <= M_DLY;
                    end
                    M_DLY: begin
                        // half period after the stop that freed the bus
                        if (tick) begin                     // [R7]
                            master <= 1'b1;
                            sda_m_low <= 1'b1;
                            mstate <= M_SDA;
                        end
                    end
                    M_SDA: begin
                        if (tick) begin
                            scl_m_low <= 1'b1;
                            si <= 1'b1;
                            status <= rs_flag ? `ST_RSTART : `ST_START;
                            mstate <= M_XFER;
                        end
                    end
                    M_XFER: begin
                        // keep SDA low until SCL is seen low after start
                        if (scl_fall) sda_m_low <= 1'b0;
                        if (si) begin
                            scl_m_low <= 1'b1;
                        end else if (si_fell && stop_request_flag) begin
                            sda_m_low <= 1'b1;              // [R10] [R12]
                            mstate <= M_STOP1;
                        end else if (si_fell && start_request_flag) begin
                            rs_flag <= 1'b1;                // [R8]
                            mstate <= M_RS1;
                        end else if (scl_m_low && tick) begin
                            scl_m_low <= 1'b0;
                        end else if (!scl_m_low && scl_s && tick) begin
                            scl_m_low <= 1'b1;
                        end
                    end
                    M_STOP1: begin
                        if (tick) begin
                            scl_m_low <= 1'b0;
                            mstate <= M_STOP2;
                        end
                    end
                    M_STOP2: begin
                        // wait for SCL really high, stretching counts
                        if (scl_s && tick) begin
                            sda_m_low <= 1'b0;
                            mstate <= M_STOP3;
                        end
                    end
                    M_STOP3: begin
                        if (stop_det) begin
                            stop_request_flag <= 1'b0;                    // [R10] [R2]
                            master <= 1'b0;
                            mstate <= start_request_flag ? M_DLY : M_IDLE; // [R12]
                        end
                    end
                    M_RS1: begin
                        if (tick) begin
                            scl_m_low <= 1'b0;
                            mstate <= M_RS2;
                        end
                    end
                    M_RS2: begin
                        if (scl_s && tick) begin
                            sda_m_low <= 1'b1;              // [R8]
                            mstate <= M_SDA;
                        end
                    end
                    default: begin
                        mstate <= M_IDLE;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // pins, interrupt and read port
    // ---------------------------------------------------------------
    // registered so outputs never glitch; costs one cycle of lag
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            scl_oe  <= 1'b0;
            sda_oe  <= 1'b0;
            irq     <= 1'b0;
            rdata   <= 8'h00;
        end else begin
            scl_out <= 1'b0;
            sda_out <= 1'b0;
            // slave stretches SCL while the cpu serves the event
            scl_oe  <= en & (scl_m_low | (~master & addressed & si)); // [R21]
            sda_oe  <= en & (sda_m_low | eng_low);                    // [R13]
            irq     <= si & global_irq_enable & bus_irq_enable;       // [R16]
            rdata   <= 8'h00;
            if (rd_en) begin
                case (addr)
                    `CTRL_ADDR: rdata <= {1'b0, en, start_request_flag, stop_request_flag, si, aa, 1'b0, scl_source_select}; // [R1]
                    `STAT_ADDR: rdata <= status;
                    `DATA_ADDR: rdata <= shift;
                    `OWN_ADDR:  rdata <= own_addr;
                    `SCLH_ADDR: rdata <= scl_high_count;
                    `SCLL_ADDR: rdata <= scl_low_count;
                    default:    rdata <= 8'h00;
                endcase
            end
        end
    end
endmodule // two_wire_bus_control
`default_nettype wire

// >>> src/bus_control_regs.vh
// bus_control_regs.vh: offsets, bit positions, resets, status codes
// assumes: included by bare name from the top module only
`ifndef BUS_CONTROL_REGS_VH
`define BUS_CONTROL_REGS_VH
// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define CTRL_ADDR   8'hd8
`define STAT_ADDR   8'hd9
`define DATA_ADDR   8'hda
`define OWN_ADDR    8'hdb
`define SCLL_ADDR   8'hdc
`define SCLH_ADDR   8'hdd
// ---------------------------------------------------------------
// control register bits
// ---------------------------------------------------------------
`define EN_BIT      6
`define STA_BIT     5
`define STO_BIT     4
`define SI_BIT      3
`define AA_BIT      2
`define SCL_SOURCE_SELECT_BIT   0
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define BYTE_RST    8'h00
`define SCL_RST     8'h00
`define STAT_RST    8'hf8
// ---------------------------------------------------------------
// status codes
// ---------------------------------------------------------------
`define ST_NONE     8'hf8
`define ST_START    8'h08
`define ST_RSTART   8'h10
`define ST_MW_ACK   8'h18
`define ST_MW_NACK  8'h20
`define ST_MT_ACK   8'h28
`define ST_MT_NACK  8'h30
`define ST_ARB      8'h38
`define ST_MR_ACK   8'h40
`define ST_MR_NACK  8'h48
`define ST_MD_ACK   8'h50
`define ST_MD_NACK  8'h58
`define ST_SW       8'h60
`define ST_SG       8'h70
`define ST_SD_ACK   8'h80
`define ST_SD_NACK  8'h88
`define ST_SGD_ACK  8'h90
`define ST_SGD_NACK 8'h98
`define ST_SSTOP    8'ha0
`define ST_SR       8'ha8
`define ST_ST_ACK   8'hb8
`define ST_ST_NACK  8'hc0
`endif

// >>> src/bit_sync.v
// bit_sync.v: two-flop synchroniser for one bus line
// assumes: line idles high, so both flops reset to one
`timescale 1ns/1ps
`default_nettype none
module bit_sync (
    input  wire clk,
    input  wire rst_b,
    input  wire d,
    output reg  q
);
    reg meta;
    // ---------------------------------------------------------------
    // two stages; only the second is read outside
    // ---------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta <= 1'b1;
            q    <= 1'b1;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule // bit_sync
`default_nettype wire

// >>> src/scl_rate_gen.v
// scl_rate_gen.v: half-period tick for the master clock
// assumes: timer pulse is one clk cycle wide and on clk
`timescale 1ns/1ps
`default_nettype none
module scl_rate_gen (
    input  wire       clk,
    input  wire       rst_b,
    input  wire       use_timer,
    input  wire       timer_ovf,
    input  wire       restart,
    input  wire       scl_high,
    input  wire [7:0] high_cnt,
    input  wire [7:0] low_cnt,
    output wire       tick
);
    reg  [7:0] count;
    wire [7:0] raw = scl_high ? high_cnt : low_cnt;
    // a zero count would wrap to a 256-clock phase, so treat it as one
    wire [7:0] lim = (raw == 8'h00) ? 8'h01 : raw;
    wire       int_tick = ~restart & (count == lim - 8'h01);
    // each overflow ends one half period: bit rate is ovf / 2
    assign tick = use_timer ? timer_ovf : int_tick;
    // ---------------------------------------------------------------
    // phase counter, restarted on every SCL, state or event-flag change
    // ---------------------------------------------------------------
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= 8'h00;
        end else if (restart | int_tick) begin
            count <= 8'h00;
        end else begin
            count <= count + 8'h01;
        end
    end
endmodule // scl_rate_gen
`default_nettype wire

// >>> verification/bus_partner.sv
// bus_partner.sv: pull-ups, one acking slave and a timer 1 source
// assumes: open-drain enables from the device, same clock
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       scl_oe,
    input  wire logic       sda_oe,
    input  wire logic [7:0] reload,
    output logic            scl_in,
    output logic            sda_in,
    output logic            timer_ovf
);
    logic       ack_oe;
    logic       scl_d;
    logic       sda_d;
    logic [3:0] bits;
    logic [7:0] tcnt;
    // wired-and, released lines float up
    assign scl_in = !scl_oe;
    assign sda_in = !(sda_oe || ack_oe);
    // slave acks the first byte only; 4'hf parks the counter
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {scl_d, sda_d, ack_oe, bits} <= {3'b110, 4'hf};
        end else begin
            scl_d <= scl_in;
            sda_d <= sda_in;
            if (scl_in && sda_d && !sda_in) bits <= 4'h0;
            else if (scl_d && !scl_in && bits != 4'hf) bits <= bits + 4'h1;
            ack_oe <= (bits == 4'h9);
        end
    end
    // timer 1 in 8-bit auto-reload: period is 256 minus reload
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) {tcnt, timer_ovf} <= 9'h000;
        else begin
            timer_ovf <= (tcnt == 8'hff);
            tcnt <= (tcnt == 8'hff) ? reload : tcnt + 8'h1;
        end
    end
endmodule // bus_partner
`default_nettype wire

// >>> verification/two_wire_bus_control_assertions.sv
// two_wire_bus_control_assertions.sv: port checker, bound below
// assumes: cpu port and pins on clk, async active-low reset
`timescale 1ns/1ps
`default_nettype none
module two_wire_bus_control_assertions (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] rdata,
    input wire logic       global_irq_enable,
    input wire logic       bus_irq_enable,
    input wire logic       irq,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       sda_out,
    input wire logic       sda_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    logic en_sh;
    // enable bit as software last wrote it
    always @(posedge clk or negedge rst_b)
        if (!rst_b) en_sh <= 1'b0;
        else if (wr_en && addr == 8'hd8) en_sh <= wdata[6];
    sequence s_ctrl_wr; wr_en && addr == 8'hd8; endsequence
    sequence s_ctrl_rd; rd_en && addr == 8'hd8; endsequence
    a_pins_open_drain: assert property (!scl_out && !sda_out)
        else $error("pin data not low");
    a_irq_gated: assert property (irq |-> $past(global_irq_enable && bus_irq_enable))
        else $error("irq without enables");
    a_rdata_idle: assert property (!$past(rd_en) |-> rdata == 8'h00)
        else $error("rdata outside read slot");
    a_unmapped_zero: assert property (rd_en && (addr < 8'hd8 || addr > 8'hdd) |=> !rdata)
        else $error("unmapped read not zero");
    a_reserved_zero: assert property (s_ctrl_rd |=> !rdata[7] && !rdata[1])
        else $error("reserved bit set");
    a_ctrl_readback: assert property (s_ctrl_wr ##1 !wr_en ##1 s_ctrl_rd |=>
        {rdata[6], rdata[2], rdata[0]} == $past({wdata[6], wdata[2], wdata[0]}, 3))
        else $error("control readback");
    a_off_quiet: assert property (!en_sh [*3] |-> !scl_oe && !sda_oe)
        else $error("lines driven while off");
    a_status_low: assert property (rd_en && addr == 8'hd9 |=> rdata[2:0] == 3'h0)
        else $error("status low bits");
endmodule // two_wire_bus_control_assertions
bind two_wire_bus_control two_wire_bus_control_assertions i_chk (.clk, .rst_b, .addr,
    .wdata, .wr_en, .rd_en, .rdata, .global_irq_enable, .bus_irq_enable, .irq, .scl_out,
    .scl_oe, .sda_out, .sda_oe);
`default_nettype wire

// >>> verification/tb.sv
// tb.sv: register, master start/stop and disable scenarios
// assumes: bus_partner supplies pull-ups, an acking slave, timer 1
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic       clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0, irq, sda_q = 1'b1;
    logic       global_irq_enable = 1'b1, bus_irq_enable = 1'b1, timer_ovf;
    logic       scl_in, sda_in, scl_out, scl_oe, sda_out, sda_oe;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d, reload = 8'hfa;
    int         n_errors = 0, checked = 0, starts = 0, stops = 0;
    always #10 clk = ~clk;
    two_wire_bus_control i_two_wire_bus_control (.clk, .rst_b, .addr, .wdata, .wr_en,
        .rd_en, .rdata, .timer_ovf, .global_irq_enable, .bus_irq_enable, .irq, .scl_in,
        .scl_out, .scl_oe, .sda_in, .sda_out, .sda_oe);
    bus_partner i_bus_partner (.clk, .rst_b, .scl_oe, .sda_oe, .reload, .scl_in, .sda_in,
        .timer_ovf);
    // start and stop conditions seen on the wires
    always @(posedge clk) begin
        sda_q <= sda_in;
        if (scl_in && sda_q && !sda_in) starts++;
        if (scl_in && !sda_q && sda_in) stops++;
    end
    task automatic check(input logic [7:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t saw %h wanted %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, v);
        @(posedge clk) {addr, wdata, wr_en} <= {a, v, 1'b1};
        @(posedge clk) wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk) {addr, rd_en} <= {a, 1'b1};
        @(posedge clk) rd_en <= 1'b0;
        @(negedge clk) d = rdata;
    endtask
    // bounded poll of a masked register field
    task automatic poll(input logic [7:0] a, m, exp);
        for (int i = 0; i < 100 && (d & m) !== exp; i++) rd(a);
        check(d & m, exp);
    endtask
    task automatic t_regs();
        rd(8'hd8);
        check(d, 8'h00);
        rd(8'hd9);
        check(d, 8'hf8);
        rd(8'he0);
        check(d, 8'h00);
        wr(8'hd8, 8'h45);
        rd(8'hd8);
        check(d, 8'h45);
        wr(8'hd8, 8'h4d);
        rd(8'hd8);
        check(d, 8'h45);
        wr(8'hd8, 8'h50);
        poll(8'hd8, 8'hff, 8'h40);
        check(8'(starts + stops), 8'h00);
    endtask
    // one address byte as master, then stop; high phase bounded by lo..hi
    task automatic t_master(input logic [7:0] ctl, lo, hi);
        int s0 = starts, t0 = stops;
        logic [7:0] n = 8'h00;
        wr(8'hd8, ctl);
        poll(8'hd9, 8'hff, 8'h08);
        check({7'h0, irq}, 8'h01);
        global_irq_enable <= 1'b0;
        rd(8'hd9);
        check({7'h0, irq}, 8'h00);
        global_irq_enable <= 1'b1;
        check(8'(starts - s0), 8'h01);
        wr(8'hda, 8'ha0);
        wr(8'hd8, ctl & 8'h45);
        for (int i = 0; i < 300 && !scl_in; i++) @(posedge clk);
        for (int i = 0; i < 300 && scl_in; i++) @(posedge clk) n++;
        check({7'h0, n >= lo && n <= hi}, 8'h01);
        poll(8'hd9, 8'hff, 8'h18);
        wr(8'hd8, (ctl & 8'h45) | 8'h10);
        poll(8'hd8, 8'h10, 8'h00);
        check(8'(stops - t0), 8'h01);
    endtask
    task automatic tally_and_finish();
        if (n_errors == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        #200000;
        n_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        t_regs();
        wr(8'hdc, 8'h04);
        wr(8'hdd, 8'h04);
        t_master(8'h64, 8'd4, 8'd8);
        t_master(8'h65, 8'd5, 8'd9);
        wr(8'hd8, 8'h00);
        rd(8'hd8);
        check({6'h0, scl_in, sda_in}, 8'h03);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
